// *** dv/dourc_host.sv ***
// host model: bit-serial register writes toward the control block
// assumes clk is the core clock; sclk is paced at 125 ns from it
module dourc_host (
  // pacing clock
  input wire logic clk,
  // serial pins
  output logic cs_n,
  output logic sclk,
  output logic sdi
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle: select high, link clock parked high
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    sdi = 1'b0;
  end
  // msb first, 24 falling edges, select high only between frames
  task automatic send(input logic [23:0] w);
    @(negedge clk);
    cs_n = 1'b0; // never used while reset pin is low
    for (int i = 23; i >= 0; i--) begin
      sdi = w[i];
      repeat (12) @(negedge clk);
      sclk = 1'b0;
      repeat (13) @(negedge clk);
      sclk = 1'b1;
    end
    repeat (12) @(negedge clk);
    cs_n = 1'b1;
    sdi = ~sdi; // released line shows no stale bit
  endtask
endmodule

// *** dv/tb_top.sv ***
// testbench for the output update and reset control block
// assumes dourc_host drives the serial pins; inputs move on falling clk
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import dourc_pkg::*;
  logic clk, rst_n, clear_n, reset_pin_n, load_strobe_n, rsel, fmt, single;
  logic cs_n, sclk, sdi, sdo, sdo_oe, offset_on, async_mode, mon_en;
  dourc_out_s [7:0] chan_out;
  logic [11:0] ofs_a, ofs_b, input_data;
  logic [3:0] mon_sel;
  logic [1:0] group_ready;
  int n_errors = 0;
  int compares = 0;
  int n;
  dourc_ctrl #(.RECOV_CYC(16)) DUT (.clk(clk), .rst_n(rst_n), .clear_n(clear_n), .reset_pin_n(reset_pin_n),
    .load_strobe_n(load_strobe_n), .reset_value_select(rsel), .input_format_select(fmt),
    .single_supply(single), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
    .chan_out(chan_out), .offset_code_a(ofs_a), .offset_code_b(ofs_b), .offset_on(offset_on),
    .input_data(input_data), .monitor_sel(mon_sel), .monitor_out_en(mon_en), .async_mode(async_mode),
    .group_ready(group_ready));
  dourc_host host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi));
  // 200 MHz core clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // compare and count
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic done_t(input string s);
    $display("test %s done", s);
  endtask
  // write a register, then let the word settle before any load
  task automatic wr(input logic [4:0] a, input logic [11:0] d);
    host.send({1'b0, a, d, 6'h00});
    cyc(8); // wait past select rise
  endtask
  task automatic strobe();
    load_strobe_n = 1'b0;
    cyc(6);
    load_strobe_n = 1'b1;
    cyc(6);
  endtask
  // power-on with strobe level choosing the mode
  task automatic por(input logic lvl);
    rst_n = 1'b0;
    load_strobe_n = lvl; // held steady over power-on
    cyc(20);
    rst_n = 1'b1;
    cyc(6);
  endtask
  task automatic end_sim();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // watchdog
  initial begin
    #400us;
    n_errors++;
    end_sim();
  end
  // main sequence
  initial begin
    {clear_n, reset_pin_n, rsel, fmt, single, rst_n, load_strobe_n} = 7'b1110001;
    por(1'b1);
    chk("code3", 12'h800, chan_out[3].code); // reset code
    chk("ofs_a", 12'h99a, ofs_a); // offset
    chk("ofs_b", 12'h99a, ofs_b); // offset group b
    chk("in_data", 12'h000, input_data); // input reg
    chk("async", 12'h000, async_mode); // sync mode
    done_t("power_on");
    wr(DOURC_A_CH0 + 5'd3, 12'h5a5);
    chk("held", 12'h800, chan_out[3].code); // no load yet
    strobe();
    chk("code3", 12'h5a5, chan_out[3].code); // strobe load
    chk("code2", 12'h800, chan_out[2].code); // untouched
    wr(DOURC_A_CH0 + 5'd5, 12'h3c3);
    wr(DOURC_A_CFG, 12'h001);
    chk("ld_bit", 12'h3c3, chan_out[5].code); // load bit
    done_t("update");
    wr(DOURC_A_CH0 + 5'd4, 12'h0f0);
    clear_n = 1'b0;
    cyc(6);
    chk("tie", 12'h001, chan_out[3].gnd_tie); // grounded
    chk("drive", 12'h000, chan_out[3].drive); // buffer off
    strobe();
    chk("ign", 12'h800, chan_out[4].code); // strobe ignored
    clear_n = 1'b1;
    cyc(6);
    chk("still", 12'h001, chan_out[3].gnd_tie); // stays cleared
    chk("kept", 12'h5a5, chan_out[3].code); // latch kept
    strobe();
    chk("back", 12'h001, chan_out[3].drive); // restored
    done_t("clear");
    wr(DOURC_A_CFG, 12'h004);
    chk("pd_tie", 12'h001, chan_out[0].gnd_tie); // group down
    chk("rdy", 12'h002, {1'b0, group_ready}); // only group a down, b ready
    wr(DOURC_A_CFG, 12'h000);
    n = 0;
    while (group_ready[0] !== 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    chk("recov", 12'h001, n < 40); // bounded recovery
    done_t("power_down");
    for (int s = 0; s < 16; s++) begin
      wr(DOURC_A_MON, {7'h00, 1'b1, s[3:0]});
      chk("mon_sel", {8'h00, s[3:0]}, mon_sel); // every source
    end
    wr(DOURC_A_MON, 12'h003);
    chk("mon_en", 12'h000, mon_en); // disabled
    done_t("monitor");
    reset_pin_n = 1'b0;
    cyc(6);
    chk("hw_code", 12'h800, chan_out[3].code); // reset pin
    chk("sdo_oe", 12'h000, sdo_oe); // output off
    reset_pin_n = 1'b1;
    cyc(6);
    chk("after", 12'h800, chan_out[3].code); // value kept
    wr(DOURC_A_CH0 + 5'd3, 12'h123);
    strobe();
    chk("resume", 12'h123, chan_out[3].code); // serial back
    done_t("hw_reset");
    {fmt, single} = 2'b11;
    por(1'b0);
    chk("ss_code", 12'h000, chan_out[3].code); // equal pins
    chk("ofs_on", 12'h000, offset_on); // offset off
    chk("async", 12'h001, async_mode); // async mode
    wr(DOURC_A_CH0 + 5'd1, 12'habc);
    chk("async_ld", 12'habc, chan_out[1].code); // select rise load
    wr(DOURC_A_CFG, 12'h002);
    wr(DOURC_A_CH0 + 5'd2, 12'h777);
    cyc(8);
    chk("eng_ld", 12'h777, chan_out[2].code); // engine write loads latch
    chk("eng_keep", 12'habc, chan_out[1].code); // other channel untouched
    done_t("async");
    end_sim();
  end
endmodule

// *** verilog/dourc_ctrl.sv ***
// channel latch update, clear, reset and power-down control
// assumes serial pins and control pins arrive asynchronously; core on clk
module dourc_ctrl #(
  parameter int RECOV_CYC = dourc_pkg::DOURC_RECOV_CYC
) (
  // clock and power-on reset
  input wire logic clk,
  input wire logic rst_n,
  // control pins
  input wire logic clear_n,
  input wire logic reset_pin_n,
  input wire logic load_strobe_n,
  input wire logic reset_value_select,
  input wire logic input_format_select,
  input wire logic single_supply,
  // serial pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  // channel outputs
  output dourc_pkg::dourc_out_s [7:0] chan_out,
  output logic [11:0] offset_code_a,
  output logic [11:0] offset_code_b,
  output logic offset_on,
  output logic [11:0] input_data,
  // monitor and status
  output logic [3:0] monitor_sel,
  output logic monitor_out_en,
  output logic async_mode,
  output logic [1:0] group_ready
);
  import dourc_pkg::*;

  // two-stage synchronisers for the clear, reset, strobe and serial pins
  logic [5:0] s1_r, s2_r, s3_r;
  always_ff @(posedge clk) begin
    s1_r <= {clear_n, reset_pin_n, load_strobe_n, cs_n, sclk, sdi};
    s2_r <= s1_r;
    s3_r <= s2_r;
  end
  logic clr_s, rstp_s, ld_s, cs_s, sck_s, sdi_s;
  assign {clr_s, rstp_s, ld_s, cs_s, sck_s, sdi_s} = s2_r;
  logic ld_fall, cs_rise, cs_fall, sck_fall;
  assign ld_fall = s3_r[3] & ~ld_s;
  assign cs_rise = ~s3_r[2] & cs_s;
  assign cs_fall = s3_r[2] & ~cs_s;
  assign sck_fall = s3_r[1] & ~sck_s;

  // reset values chosen by pins
  logic [11:0] rst_code, rst_ofs;
  assign rst_code = (reset_value_select == input_format_select) ? DOURC_ZERO_CODE : DOURC_MID_CODE;
  assign rst_ofs = single_supply ? DOURC_OFS_OFF : (input_format_select ? DOURC_OFS_BTC : DOURC_OFS_USB);
  logic hw_rst;
  assign hw_rst = ~rst_n | ~rstp_s;

  // update mode captured after power-on reset release
  logic mode_done_r, async_r;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_done_r <= 1'b0;
      async_r <= 1'b0;
    end else if (!mode_done_r) begin
      mode_done_r <= 1'b1;
      async_r <= ~ld_s;
    end
  end
  assign async_mode = async_r;

  // serial shift register, blocked in reset or with chip select high
  logic [23:0] sr_r;
  logic [4:0] cnt_r;
  always_ff @(posedge clk) begin
    if (hw_rst || cs_fall) begin
      sr_r <= '0;
      cnt_r <= '0;
    end else if (!cs_s && sck_fall) begin
      sr_r <= {sr_r[22:0], sdi_s};
      if (cnt_r != 5'd24) cnt_r <= cnt_r + 5'd1;
    end
  end
  assign sdo = sr_r[DOURC_SR_LEN-1];
  assign sdo_oe = ~hw_rst & ~cs_s;
  logic wr_ev;
  logic [4:0] wa;
  logic [11:0] wd;
  assign wr_ev = cs_rise & ~hw_rst & (cnt_r == 5'd24) & ~sr_r[DOURC_RW_POS];
  assign wa = sr_r[DOURC_ADDR_LSB +: DOURC_AW];
  assign wd = sr_r[DOURC_DATA_LSB +: DOURC_DW];

  // control registers; clear does not touch them
  logic [11:0] cfg_r, mon_r, gain_r;
  logic ld_req;
  assign ld_req = wr_ev && wa == DOURC_A_CFG && wd[DOURC_CFG_LD];
  always_ff @(posedge clk) begin
    if (hw_rst) begin
      cfg_r <= '0;
      mon_r <= '0;
      gain_r <= '0;
    end else if (wr_ev) begin
      if (wa == DOURC_A_CFG) cfg_r <= wd & ~12'h001;
      if (wa == DOURC_A_MON) mon_r <= wd;
      if (wa == DOURC_A_GAIN) gain_r <= wd;
    end
  end
  assign monitor_sel = mon_r[3:0];
  assign monitor_out_en = mon_r[DOURC_MON_EN];

  // offset converters reload default on reset or gain change
  always_ff @(posedge clk) begin
    if (hw_rst || (wr_ev && wa == DOURC_A_GAIN && wd != gain_r)) begin
      offset_code_a <= rst_ofs;
      offset_code_b <= rst_ofs;
    end
  end
  assign offset_on = ~single_supply;

  // channel data registers, pending flags and latches
  logic [11:0] data_r [8];
  logic [11:0] latch_r [8];
  logic [7:0] pend_r, eng_pend_r;
  logic [2:0] eng_cnt_r;
  dourc_eng_e eng_r;
  logic correction_engine_enable;
  assign correction_engine_enable = cfg_r[DOURC_CFG_SCE];
  logic sync_load;
  assign sync_load = ~async_r & (ld_fall | ld_req) & clr_s;
  logic wr_ch;
  assign wr_ch = wr_ev & (wa >= DOURC_A_CH0) & (wa < DOURC_A_CH0 + 5'd8);

  // correction engine stand-in: writes one pending channel every few cycles
  logic [7:0] eng_bit;
  assign eng_bit = eng_pend_r & (~eng_pend_r + 8'd1);
  always_ff @(posedge clk) begin
    if (hw_rst) begin
      eng_r <= DOURC_IDLE;
      eng_cnt_r <= '0;
    end else begin
      unique case (eng_r)
        DOURC_IDLE: if (eng_pend_r != 0) eng_r <= DOURC_ENG;
        DOURC_ENG: begin
          eng_cnt_r <= eng_cnt_r + 3'd1;
          if (eng_cnt_r == 3'(DOURC_ENG_CYC - 1)) eng_r <= DOURC_HOLD;
        end
        DOURC_HOLD: begin
          eng_cnt_r <= '0;
          eng_r <= DOURC_IDLE;
        end
        default: eng_r <= DOURC_IDLE;
      endcase
    end
  end
  logic eng_wr;
  assign eng_wr = (eng_r == DOURC_HOLD);

  // data, pending and latch updates per channel
  always_ff @(posedge clk) begin
    for (int i = 0; i < DOURC_CH; i++) begin
      if (hw_rst) begin
        data_r[i] <= rst_code;
        latch_r[i] <= rst_code;
        pend_r[i] <= 1'b0;
        eng_pend_r[i] <= 1'b0;
      end else begin
        if (wr_ch && wa == DOURC_A_CH0 + 5'(i)) begin
          data_r[i] <= wd;
          if (correction_engine_enable) eng_pend_r[i] <= 1'b1;
          else if (async_r) latch_r[i] <= wd;
          else pend_r[i] <= 1'b1;
        end else if (eng_wr && eng_bit[i]) begin
          eng_pend_r[i] <= 1'b0;
          if (async_r) latch_r[i] <= data_r[i];
          else pend_r[i] <= 1'b1;
        end else if (sync_load && pend_r[i] && !eng_pend_r[i]) begin
          latch_r[i] <= data_r[i];
          pend_r[i] <= 1'b0;
        end
      end
    end
  end

  // clear hold: once cleared, stays until strobe low
  logic cleared_r;
  always_ff @(posedge clk) begin
    if (hw_rst) cleared_r <= 1'b0;
    else if (!clr_s) cleared_r <= 1'b1;
    else if (!ld_s) cleared_r <= 1'b0;
  end
  assign input_data = '0;

  // power-down recovery timers per group
  logic [1:0] pd;
  assign pd = {cfg_r[DOURC_CFG_PDB], cfg_r[DOURC_CFG_PDA]};
  logic [31:0] rec_r [2];
  always_ff @(posedge clk) begin
    for (int g = 0; g < 2; g++) begin
      if (hw_rst) rec_r[g] <= '0;
      else if (pd[g]) rec_r[g] <= 32'(RECOV_CYC);
      else if (rec_r[g] != 0) rec_r[g] <= rec_r[g] - 32'd1;
    end
  end
  assign group_ready = {~pd[1] & (rec_r[1] == 0), ~pd[0] & (rec_r[0] == 0)};

  // output drive per channel; group a = 0..3, group b = 4..7
  always_comb begin
    for (int i = 0; i < DOURC_CH; i++) begin
      chan_out[i].code = latch_r[i];
      chan_out[i].gnd_tie = cleared_r | ~clr_s | pd[i/4];
      chan_out[i].drive = ~chan_out[i].gnd_tie;
    end
  end

  // checks
  a_clear_ties_gnd: assert property (@(posedge clk) disable iff (!rst_n) !clr_s |-> chan_out[0].gnd_tie)
    else $error("clear did not tie outputs");
  a_clear_holds_latch: assert property (@(posedge clk) disable iff (hw_rst) (!clr_s && !wr_ev && !eng_wr) |=> $stable(latch_r[0]))
    else $error("clear changed a latch");
  a_sync_no_update: assert property (@(posedge clk) disable iff (hw_rst) (!async_r && !sync_load && !wr_ev && !eng_wr) |=> $stable(latch_r[1]))
    else $error("latch moved without load");
  a_reset_code: assert property (@(posedge clk) hw_rst |=> latch_r[2] == $past(rst_code))
    else $error("reset code wrong");
  a_reset_sdo_off: assert property (@(posedge clk) hw_rst |-> !sdo_oe)
    else $error("serial output driven in reset");
  a_pd_ties: assert property (@(posedge clk) disable iff (hw_rst) pd[1] |-> chan_out[7].gnd_tie)
    else $error("power-down not tied");
  a_recover_bound: assert property (@(posedge clk) disable iff (hw_rst) $fell(pd[0]) |-> rec_r[0] <= 32'(RECOV_CYC))
    else $error("recovery too long");
  a_mon_follow: assert property (@(posedge clk) disable iff (hw_rst) (wr_ev && wa == DOURC_A_MON) |=> monitor_sel == $past(wd[3:0]))
    else $error("monitor select wrong");

  // asynchronous mode, engine off: a channel word lands in its latch next cycle
  sequence s_async_ch1_wr;
    async_r && !correction_engine_enable && wr_ch && wa == DOURC_A_CH0 + 5'd1;
  endsequence
  a_async_update: assert property (@(posedge clk) disable iff (hw_rst) s_async_ch1_wr |=> latch_r[1] == $past(wd))
    else $error("async write missed latch");

  // asynchronous mode, engine on: the engine's write loads the latch
  sequence s_eng_ch1_wr;
    async_r && eng_wr && eng_bit[1] && !wr_ch;
  endsequence
  a_engine_update: assert property (@(posedge clk) disable iff (hw_rst) s_eng_ch1_wr |=> latch_r[1] == $past(data_r[1]))
    else $error("engine write missed latch");

  // load request bit never stays set in the register
  a_ld_self_clr: assert property (@(posedge clk) disable iff (hw_rst) ld_req |=> !cfg_r[DOURC_CFG_LD])
    else $error("load request stuck");

  // a pending channel follows its data register on a synchronous load
  a_sync_load_pend: assert property (@(posedge clk) disable iff (hw_rst) (sync_load && pend_r[3] && !eng_pend_r[3] && !wr_ch && !eng_wr) |=> latch_r[3] == $past(data_r[3]))
    else $error("pending latch not loaded");

  // a channel not written since the last load is left alone
  a_idle_ch_kept: assert property (@(posedge clk) disable iff (hw_rst) (sync_load && !pend_r[6] && !wr_ch && !eng_wr) |=> $stable(latch_r[6]))
    else $error("idle channel reloaded");

  // a short word never reaches the registers
  a_short_word: assert property (@(posedge clk) disable iff (hw_rst) (cs_rise && cnt_r != 5'd24) |-> !wr_ev)
    else $error("short word accepted");

  // a new gain setting puts the offset converters back to default
  a_gain_reload: assert property (@(posedge clk) disable iff (hw_rst) (wr_ev && wa == DOURC_A_GAIN && wd != gain_r) |=> offset_code_a == $past(rst_ofs))
    else $error("offset not reloaded on gain change");

  // serial output stays released while select is high
  a_sdo_cs_high: assert property (@(posedge clk) cs_s |-> !sdo_oe)
    else $error("serial output driven while deselected");

  // after clear release, outputs stay tied until the strobe goes low
  a_clear_hold: assert property (@(posedge clk) disable iff (hw_rst) (cleared_r && ld_s) |-> chan_out[2].gnd_tie)
    else $error("clear hold released early");

  // update mode does not move once captured
  a_mode_fixed: assert property (@(posedge clk) disable iff (!rst_n) mode_done_r |=> $stable(async_r))
    else $error("update mode changed");
endmodule

// *** verilog/dourc_pkg.sv ***
// package for the converter output update and reset control block
// assumes a 200 MHz core clock; shared by the control module and the testbench
package dourc_pkg;
  localparam int DOURC_CH = 8;
  localparam int DOURC_DW = 12;
  localparam int DOURC_AW = 5;
  // reset codes
  localparam logic [11:0] DOURC_ZERO_CODE = 12'h000;
  localparam logic [11:0] DOURC_MID_CODE = 12'h800;
  localparam logic [11:0] DOURC_OFS_USB = 12'h99a;
  localparam logic [11:0] DOURC_OFS_BTC = 12'h19a;
  localparam logic [11:0] DOURC_OFS_OFF = 12'h000;
  // serial word layout: rw, 5 address bits, 12 data bits, 6 spare bits
  localparam int DOURC_SR_LEN = 24;
  localparam int DOURC_RW_POS = 23;
  localparam int DOURC_ADDR_LSB = 18;
  localparam int DOURC_DATA_LSB = 6;
  // register addresses; channel data at 8..15
  localparam logic [4:0] DOURC_A_CH0 = 5'h08;
  localparam logic [4:0] DOURC_A_CFG = 5'h00;
  localparam logic [4:0] DOURC_A_MON = 5'h01;
  localparam logic [4:0] DOURC_A_GAIN = 5'h02;
  // configuration field positions
  localparam int DOURC_CFG_LD = 0;
  localparam int DOURC_CFG_SCE = 1;
  localparam int DOURC_CFG_PDA = 2;
  localparam int DOURC_CFG_PDB = 3;
  // monitor field positions
  localparam int DOURC_MON_EN = 4;
  // timing
  localparam int DOURC_CLK_PS = 5000;
  localparam int DOURC_RECOV_US = 200;
  localparam int DOURC_RECOV_CYC = (DOURC_RECOV_US * 1000000) / DOURC_CLK_PS;
  localparam int DOURC_ENG_CYC = 4;
  // sequencer states
  typedef enum logic [2:0] {
    DOURC_IDLE = 3'b001,
    DOURC_ENG = 3'b010,
    DOURC_HOLD = 3'b100
  } dourc_eng_e;
  // one channel's analog control
  typedef struct packed {
    logic [11:0] code;
    logic drive;
    logic gnd_tie;
  } dourc_out_s;
endpackage
